// [rtl/pfs_params.svh]
// fixed build-time constants of the pixel fix stream port
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ----------------------------------------------------------------------
// constant configuration
// ----------------------------------------------------------------------
`define PFS_PIX_BITS 8
`define PFS_LINE_PIX 1920
`define PFS_THR_SPATIAL 64
`define PFS_THR_TEMPORAL 64

// ----------------------------------------------------------------------
// stream widths
// ----------------------------------------------------------------------
`define PFS_BYTE_BITS 8
`define PFS_IN_WIDE 16
`define PFS_RGB_PARTS 3

// ----------------------------------------------------------------------
// buffering
// ----------------------------------------------------------------------
`define PFS_FIFO_DEPTH 8

`endif

// [rtl/pfs_pkg.sv]
// shared types of the pixel fix stream port
package pfs_pkg;

    // ------------------------------------------------------------------
    // stream sideband carried with every pixel
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sof;
        logic line_end_flag;
    } pfs_side_t;

endpackage

// [rtl/pfs_stream_port.sv]
// pixel fix core stream port with input fifo and fixed configuration
`timescale 1ns/1ns
`include "pfs_params.svh"

// ----------------------------------------------------------------------
// fifo
// ----------------------------------------------------------------------
module pfs_fifo
    import pfs_pkg::*;
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = `PFS_FIFO_DEPTH
)
(
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_core_rst_b,
    input wire logic i_en,
    // fill side
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // drain side
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [CNT_W-1:0] count;
        logic not_full;
    } pfs_fifo_st_t;

    localparam pfs_fifo_st_t ST_RESET = '{wr: '0, rd: '0, count: '0, not_full: 1'b1};

    logic [WIDTH-1:0] mem [DEPTH];
    pfs_fifo_st_t st_reg;
    pfs_fifo_st_t st_next;
    logic push;
    logic pop;

    assign o_ready = st_reg.not_full;
    assign o_valid = (st_reg.count != '0);
    assign o_data = mem[st_reg.rd];
    // nothing moves while the core is disabled or held in reset
    assign push = i_core_rst_b & i_en & i_valid & st_reg.not_full;
    assign pop = i_core_rst_b & i_en & o_valid & i_ready;

    always_comb
    begin
        st_next = st_reg;
        if (!i_core_rst_b)
        begin
            st_next = ST_RESET;
        end
        else if (i_en)
        begin
            if (push)
            begin
                st_next.wr = (st_reg.wr == PTR_LAST) ? '0 : PTR_W'(st_reg.wr + 1'b1);
            end
            if (pop)
            begin
                st_next.rd = (st_reg.rd == PTR_LAST) ? '0 : PTR_W'(st_reg.rd + 1'b1);
            end
            st_next.count = CNT_W'(st_reg.count + CNT_W'(push) - CNT_W'(pop));
            // ready for the next edge follows the updated count
            st_next.not_full = (st_next.count != CNT_FULL);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            mem[st_reg.wr] <= i_data;
        end
    end

endmodule // pfs_fifo

// ----------------------------------------------------------------------
// top: stream port
// ----------------------------------------------------------------------
// Overview of operation
// - stream inputs sampled on the rising core clock edge; outputs change after it.
// - clock enable low freezes all state, holds outputs and ignores inputs.
// - core reset low resets the port at the next edge, even when disabled.
// - core clock, enable and reset never touch a register interface.
// - interrupt outputs exist only when configured; this build has neither.
// - rgb output packed to 24, 32 or 40 bits, unused top bits zero.
// - a transfer needs ready, valid, enable and released reset together.
// - only active video pixels travel on the streams.
// - start of frame flag marks exactly the first pixel transfer of a frame.
// - start of frame may rise early while valid stays low.
// - line end flag marks exactly the last pixel transfer of a line.
// - resolution and thresholds fixed at build time; only reset and enable control.
module pfs_stream_port
    import pfs_pkg::*;
#(
    parameter int PIX_BITS = `PFS_PIX_BITS,
    parameter int LINE_PIX = `PFS_LINE_PIX,
    parameter int THR_SPATIAL = `PFS_THR_SPATIAL,
    parameter int THR_TEMPORAL = `PFS_THR_TEMPORAL,
    parameter int FIFO_DEPTH = `PFS_FIFO_DEPTH,
    parameter int IN_W = (PIX_BITS > `PFS_BYTE_BITS) ? `PFS_IN_WIDE : `PFS_BYTE_BITS,
    parameter int OUT_W = ((`PFS_RGB_PARTS * PIX_BITS + `PFS_BYTE_BITS - 1) / `PFS_BYTE_BITS) * `PFS_BYTE_BITS
)
(
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_core_en,
    input wire logic i_core_rst_b,
    // input video stream
    input wire logic [IN_W-1:0] i_s_data,
    input wire logic i_s_valid,
    input wire pfs_side_t i_s_side,
    output logic o_s_ready,
    // output video stream
    output logic [OUT_W-1:0] o_m_data,
    output logic o_m_valid,
    output pfs_side_t o_m_side,
    input wire logic i_m_ready
);
    localparam int COL_W = (LINE_PIX > 1) ? $clog2(LINE_PIX) : 1;
    localparam int FW = IN_W + $bits(pfs_side_t);
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(LINE_PIX - 1);
    localparam logic [PIX_BITS-1:0] THR_SP = PIX_BITS'(THR_SPATIAL);
    localparam logic [PIX_BITS-1:0] THR_TM = PIX_BITS'(THR_TEMPORAL);

    typedef struct packed {
        logic out_valid;
        logic [OUT_W-1:0] out_data;
        pfs_side_t out_side;
        logic [COL_W-1:0] col;
        logic first_line;
        logic [PIX_BITS-1:0] left;
    } pfs_port_st_t;

    localparam pfs_port_st_t ST_RESET = '{out_valid: 1'b0, out_data: '0, out_side: '0,
                                          col: '0, first_line: 1'b1, left: '0};

    // magnitude of the difference between two samples
    function automatic logic [PIX_BITS-1:0] absdiff(input logic [PIX_BITS-1:0] a, input logic [PIX_BITS-1:0] b);
        absdiff = (a > b) ? PIX_BITS'(a - b) : PIX_BITS'(b - a);
    endfunction

    // previous line's corrected samples, one per column
    logic [PIX_BITS-1:0] line_mem [LINE_PIX];
    pfs_port_st_t st_reg;
    pfs_port_st_t st_next;
    logic [FW-1:0] f_data;
    logic f_valid;
    logic f_ready;
    pfs_side_t f_side;
    logic [PIX_BITS-1:0] pix;
    logic [PIX_BITS-1:0] above;
    logic [PIX_BITS-1:0] fixed;
    logic [COL_W-1:0] col_eff;
    logic take;
    logic bad;
    logic [1:0] rst_sync_reg;
    logic rst_sync_b;
    logic [`PFS_RGB_PARTS*PIX_BITS-1:0] rgb_word;

    // ------------------------------------------------------------------
    // power-on reset release
    // ------------------------------------------------------------------
    // asserts at once, releases two edges later so no flop leaves reset on a ragged edge
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end

    assign rst_sync_b = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // input buffering
    // ------------------------------------------------------------------
    pfs_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_b(rst_sync_b),
        .i_core_rst_b(i_core_rst_b),
        .i_en(i_core_en),
        .i_data({i_s_side, i_s_data}),
        .i_valid(i_s_valid),
        .o_ready(o_s_ready),
        .o_data(f_data),
        .o_valid(f_valid),
        .i_ready(f_ready)
    );

    // ------------------------------------------------------------------
    // pixel correction
    // ------------------------------------------------------------------
    // upper input bits are padding and ignored
    assign pix = f_data[PIX_BITS-1:0];
    assign f_side = f_data[FW-1:IN_W];
    // output stage reloads on the same edge that empties it
    assign f_ready = !st_reg.out_valid || i_m_ready;
    assign take = i_core_rst_b & i_core_en & f_valid & f_ready;
    assign col_eff = f_side.sof ? '0 : st_reg.col;
    assign above = line_mem[col_eff];
    // a defect differs from both neighbours beyond their thresholds
    assign bad = !f_side.sof && (st_reg.col != '0) && !st_reg.first_line
                 && (absdiff(pix, st_reg.left) > THR_SP) && (absdiff(pix, above) > THR_TM);
    assign fixed = bad ? st_reg.left : pix;

    // ------------------------------------------------------------------
    // rgb packing
    // ------------------------------------------------------------------
    // grey output: the corrected sample in every component
    for (genvar gi = 0; gi < `PFS_RGB_PARTS; gi++)
    begin : g_rgb
        assign rgb_word[gi*PIX_BITS +: PIX_BITS] = fixed;
    end

    always_comb
    begin
        st_next = st_reg;
        if (!i_core_rst_b)
        begin
            st_next = ST_RESET;
        end
        else if (i_core_en)
        begin
            if (take)
            begin
                st_next.out_valid = 1'b1;
                st_next.out_data = OUT_W'(rgb_word);
                st_next.out_side = f_side;
                st_next.left = fixed;
                // column restarts after a line end, saturates on long lines
                st_next.col = f_side.line_end_flag ? '0
                              : ((col_eff == COL_LAST) ? col_eff : COL_W'(col_eff + 1'b1));
                st_next.first_line = f_side.line_end_flag ? 1'b0 : (f_side.sof | st_reg.first_line);
            end
            else if (i_m_ready)
            begin
                st_next.out_valid = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // previous line store for the vertical neighbour
    always_ff @(posedge i_mclk)
    begin
        if (take)
        begin
            line_mem[col_eff] <= fixed;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops; no interrupt or register pins
    // ------------------------------------------------------------------
    assign o_m_valid = st_reg.out_valid;
    assign o_m_data = st_reg.out_data;
    assign o_m_side = st_reg.out_side;

endmodule // pfs_stream_port

// [verification/pfs_port_properties.sv]
// concurrent checks on the stream port pins
`timescale 1ns/1ns
module pfs_port_properties
    import pfs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int OUT_W = 24
)
(
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_core_en,
    input wire logic i_core_rst_b,
    // streams
    input wire logic i_s_valid,
    input wire logic o_s_ready,
    input wire logic [OUT_W-1:0] o_m_data,
    input wire logic o_m_valid,
    input wire pfs_side_t o_m_side,
    input wire logic i_m_ready
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    // words held between the two streams
    int occ_reg;
    logic push;
    logic pop;
    assign push = i_s_valid && o_s_ready && i_core_en && i_core_rst_b;
    assign pop = o_m_valid && i_m_ready && i_core_en && i_core_rst_b;
    always_ff @(posedge i_mclk or negedge i_rst_b)
        if (!i_rst_b)
            occ_reg <= 0;
        else if (!i_core_rst_b)
            occ_reg <= 0;
        else
            occ_reg <= occ_reg + int'(push) - int'(pop);
    core_reset_a:
        assert property (!i_core_rst_b |=> o_s_ready && !o_m_valid && o_m_side == 2'h0) else $error("reset missed");
    enable_freeze_a:
        assert property (i_core_rst_b && !i_core_en |=> $stable(o_s_ready) && $stable(o_m_valid)
            && $stable(o_m_data) && $stable(o_m_side)) else $error("outputs moved while disabled");
    out_hold_a:
        assert property (o_m_valid && !i_m_ready && i_core_rst_b |=> o_m_valid && $stable(o_m_data)
            && $stable(o_m_side)) else $error("output dropped before taken");
    grey_pack_a:
        assert property (o_m_valid |-> o_m_data == {3{o_m_data[7:0]}}) else $error("rgb packing wrong");
    rise_cause_a:
        assert property ($rose(o_m_valid) |-> $past(i_core_en) && $past(i_core_rst_b)) else $error("valid rose idle");
    occ_bound_a:
        assert property (occ_reg <= FIFO_DEPTH + 1) else $error("input taken while full");
    empty_idle_a:
        assert property (occ_reg == 0 |-> !o_m_valid) else $error("word out of nothing");
    ready_keep_a:
        assert property (o_s_ready && !push && i_core_rst_b |=> o_s_ready) else $error("ready fell without push");
endmodule // pfs_port_properties

bind pfs_stream_port pfs_port_properties #(.FIFO_DEPTH(FIFO_DEPTH), .OUT_W(OUT_W)) u_props (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_core_en(i_core_en), .i_core_rst_b(i_core_rst_b),
    .i_s_valid(i_s_valid), .o_s_ready(o_s_ready), .o_m_data(o_m_data), .o_m_valid(o_m_valid),
    .o_m_side(o_m_side), .i_m_ready(i_m_ready));

// [verification/pfs_far_model.sv]
// upstream source and downstream sink facing the stream port
`timescale 1ns/1ns
module pfs_far_model
    import pfs_pkg::*;
(
    // clock and core controls
    input wire logic i_mclk,
    input wire logic i_core_en,
    input wire logic i_core_rst_b,
    input wire logic [1:0] i_sink_mode,
    // source side
    output logic [7:0] o_data,
    output logic o_valid,
    output pfs_side_t o_side,
    input wire logic i_ready,
    // sink side
    output logic o_ready
);
    int seed = 10;
    initial
    begin
        o_data = 8'h00;
        o_valid = 1'b0;
        o_side = 2'h0;
        o_ready = 1'b0;
    end
    // sink mode 0 prompt, 1 random stalls, 2 blocked
    always @(posedge i_mclk)
        o_ready <= i_sink_mode == 2'd0 || (i_sink_mode == 2'd1 && ($random(seed) & 1) == 1);
    task automatic send(input logic [7:0] d, input pfs_side_t s);
        o_valid <= 1'b1;
        o_data <= d;
        o_side <= s;
        @(posedge i_mclk);
        while (!(i_ready && i_core_en && i_core_rst_b))
            @(posedge i_mclk);
    endtask
    // released lines show the inverse of the last word
    task automatic idle();
        o_valid <= 1'b0;
        o_data <= ~o_data;
        o_side <= ~o_side;
    endtask
endmodule // pfs_far_model

// [verification/test_pfs_stream_port.sv]
// self-checking bench for the pixel fix stream port
`timescale 1ns/1ns
module test_pfs_stream_port
    import pfs_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_core_en = 1'b1;
    logic i_core_rst_b = 1'b0;
    logic [1:0] sink_mode = 2'd0;
    logic [7:0] s_data;
    logic s_valid;
    pfs_side_t s_side;
    logic s_ready;
    logic [23:0] m_data;
    logic m_valid;
    pfs_side_t m_side;
    logic m_ready;
    logic [25:0] exp_q[$];
    logic [25:0] got;
    logic toggling = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int seed = 10;
    int cycles = 0;
    int k;
    always #5 i_mclk = ~i_mclk;
    pfs_stream_port DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_core_en(i_core_en), .i_core_rst_b(i_core_rst_b),
        .i_s_data(s_data), .i_s_valid(s_valid), .i_s_side(s_side), .o_s_ready(s_ready),
        .o_m_data(m_data), .o_m_valid(m_valid), .o_m_side(m_side), .i_m_ready(m_ready));
    pfs_far_model u_far (.i_mclk(i_mclk), .i_core_en(i_core_en), .i_core_rst_b(i_core_rst_b),
        .i_sink_mode(sink_mode), .o_data(s_data), .o_valid(s_valid), .o_side(s_side), .i_ready(s_ready),
        .o_ready(m_ready));
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_word(input logic [23:0] g, input logic [23:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_flags(input logic [1:0] g, input logic [1:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic put(input logic [7:0] d, input pfs_side_t s);
        exp_q.push_back({s, {3{d}}});
        u_far.send(d, s);
    endtask
    task automatic frame(input int lines, input int px);
        for (int l = 0; l < lines; l++)
            for (int p = 0; p < px; p++)
                put(8'($random(seed)) & 8'h3f, {l == 0 && p == 0, p == px - 1});
        u_far.idle();
    endtask
    task automatic drain(input string name);
        for (int n = 0; n < 300 && exp_q.size() > 0; n++)
            @(posedge i_mclk);
        check_flags({exp_q.size() == 0, 1'b0}, 2'b10);
        $display("test %s done", name);
    endtask
    task automatic core_reset();
        i_core_rst_b <= 1'b0;
        repeat (32) @(posedge i_mclk);
        i_core_rst_b <= 1'b1;
        @(posedge i_mclk);
        exp_q.delete();
        check_flags({s_ready, m_valid}, 2'b10);
    endtask
    // ----
    // output watcher
    // ----
    always @(posedge i_mclk)
        if (i_rst_b && i_core_rst_b && i_core_en && m_valid && m_ready)
        begin
            got = (exp_q.size() > 0) ? exp_q.pop_front() : ~26'h0;
            check_word(m_data, got[23:0]);
            check_flags(m_side, got[25:24]);
        end
    always @(posedge i_mclk)
        if (toggling)
            i_core_en <= 1'($random(seed));
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        core_reset();
        frame(2, 4);
        drain("prompt frame");
        // lone spike on line two is replaced, edges that match a neighbour are kept
        for (k = 0; k < 8; k++)
        begin
            exp_q.push_back({k == 0, k % 4 == 3, (k == 2 || k == 6) ? {3{8'hf0}} : {3{8'h10}}});
            u_far.send((k == 2 || k == 5 || k == 6) ? 8'hf0 : 8'h10, {k == 0, k % 4 == 3});
        end
        u_far.idle();
        drain("defect fix");
        sink_mode <= 2'd1;
        toggling = 1'b1;
        frame(3, 5);
        toggling = 1'b0;
        @(posedge i_mclk);
        i_core_en <= 1'b1;
        drain("stalls and enable");
        sink_mode <= 2'd2;
        for (k = 0; k < 12 && s_ready === 1'b1; k++)
        begin
            put(8'($random(seed)) & 8'h3f, 2'h0);
            u_far.idle();
            @(posedge i_mclk);
        end
        check_flags({k >= 8, k <= 9}, 2'b11);
        $display("test fill done");
        i_core_en <= 1'b0;
        core_reset();
        i_core_en <= 1'b1;
        sink_mode <= 2'd0;
        frame(1, 3);
        drain("after flush");
        print_verdict();
    end
endmodule // test_pfs_stream_port
